// File: hdl/mscr_map.vh
// register offsets, reset values and field positions of the mixer config bank
`ifndef MSCR_MAP_VH
`define MSCR_MAP_VH
`define MSCR_IDX_PORT 3'h4
`define MSCR_DATA_PORT 3'h5
`define MSCR_OFF_RESET 8'h00
`define MSCR_OFF_STEREO 8'h1e
`define MSCR_OFF_LEGACY_MV 8'h32
`define MSCR_OFF_SYNTH 8'h36
`define MSCR_OFF_CD 8'h38
`define MSCR_OFF_AUX 8'h3a
`define MSCR_OFF_SPK 8'h3c
`define MSCR_OFF_LINE 8'h3e
`define MSCR_OFF_PORTCFG 8'h40
`define MSCR_OFF_SIN 8'h42
`define MSCR_OFF_SOUT 8'h44
`define MSCR_OFF_SANA 8'h46
`define MSCR_OFF_SMISC 8'h48
`define MSCR_OFF_SDIV 8'h4c
`define MSCR_OFF_LEFT_MV 8'h60
`define MSCR_OFF_RIGHT_MV 8'h62
`define MSCR_OFF_MV_CTRL 8'h64
`define MSCR_RST_STEREO 8'h00
`define MSCR_RST_LEGACY_MV 8'h88
`define MSCR_RST_SYNTH 8'h88
`define MSCR_RST_CD 8'h00
`define MSCR_RST_AUX 8'h00
`define MSCR_RST_SPK 8'h04
`define MSCR_RST_LINE 8'h00
`define MSCR_RST_PORTCFG 8'h00
`define MSCR_RST_SERIAL 8'h00
`define MSCR_RST_MASTER 8'h36
`define MSCR_RST_MV_CTRL 8'h00
`define MSCR_BIT_STEREO 1
`define MSCR_BIT_RESTART 2
`define MSCR_BIT_JOY 1
`define MSCR_BIT_SYNTH_ALIAS 0
`define MSCR_BIT_OVERRIDE 7
`define MSCR_BIT_PREAMP 6
`define MSCR_BIT_PORT_EN 7
`define MSCR_BIT_FORMAT 6
`define MSCR_BIT_SRESET 5
`define MSCR_BIT_SYNC_LOW 3
`define MSCR_BIT_TEST 2
`define MSCR_BIT_TELEGAME 1
`define MSCR_BIT_EMU_DIS 0
`define MSCR_MIDI_BASE 10'h300
`define MSCR_JOY_ADDR 10'h201
`define MSCR_ALIAS_LO 10'h388
`define MSCR_ALIAS_HI 10'h3b8
`endif

// File: hdl/mscr_regs.v
// indexed mixer configuration register bank with serial mode controls
// Notes on behaviour
// - stereo flag resets to 00h; bit 1 enables compatibility stereo DAC behaviour.
// - filter bit 5 and no-function bits are stored but steer nothing.
// - legacy master volume at 32h holds left/right nibbles, resets to 88h.
// - synth volume resets 88h; CD, aux and line volumes reset 00h.
// - speaker volume bits 2:0 attenuate in 3 dB steps; resets to 04h.
// - port config bits 7:3,1:0 cleared by hardware reset, untouched by mixer reset.
// - bits 7:5 pick MIDI port interrupt use; bits 4:3 pick base 300h-330h.
// - bit 2 write-only; writing one disables device until the next hardware reset.
// - bit 1 decodes joystick address 201h, overriding other joystick setup.
// - bit 0 decodes synth alias range 388h-3B8h, normal synth addresses kept.
// - serial input override bit 7 substitutes source and volume in serial mode.
// - bit 6 with override bypasses 26 dB mic preamp during serial mode.
// - bits 5:4 select line, CD, mic or mixer input under override.
// - bits 3:0 replace controller input volume under serial override.
// - output override bit 7 takes output volume from bits 3:0 in serial mode.
// - bits 6:4 route speaker output in serial mode regardless of override.
// - analog bits 6:0 act only with bit 7; bits 5,4 choose ADC or DAC.
// - serial port enable bit 7 syncs to bit clock rising edge.
// - serial reset bit 5 clears toggles, shift registers, inhibits duplex out link.
// - bit 6 signed data, bit 3 active-low sync, bit 2 turns pins to outputs.
// - telegaming bit 1 feeds first channel to system DAC in serial mode, else second channel.
// - with emulation on, legacy master writes update both per-channel master registers.
// - filter divider bits 3:0 are signed divisor of serial clock in serial mode.
`timescale 1ns/1ps
`default_nettype none
`include "mscr_map.vh"
module mscr_regs #(
  parameter SHIFT_W = 16
) (
  input wire sys_clk,
  input wire reset,
  input wire [2:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire [9:0] decode_addr,
  input wire serial_mode,
  input wire serial_bit_clock_in,
  input wire serial_rx_bit,
  output wire stereo_dac_enable,
  output wire [3:0] synth_vol_left,
  output wire [3:0] synth_vol_right,
  output wire [3:0] cd_vol_left,
  output wire [3:0] cd_vol_right,
  output wire [3:0] aux_vol_left,
  output wire [3:0] aux_vol_right,
  output wire [3:0] line_vol_left,
  output wire [3:0] line_vol_right,
  output wire [2:0] speaker_atten,
  output wire [7:0] left_master_vol,
  output wire [7:0] right_master_vol,
  output wire midi_enable,
  output wire midi_irq_share,
  output wire [4:0] midi_irq_lines,
  output wire [9:0] midi_base,
  output wire midi_hit,
  output reg device_disable,
  output wire joystick_hit,
  output wire synth_alias_hit,
  input wire [1:0] app_input_source,
  input wire [3:0] app_input_volume,
  output wire [1:0] eff_input_source,
  output wire [3:0] eff_input_volume,
  output wire mic_preamp_bypass,
  output wire [3:0] eff_output_volume,
  output wire [2:0] speaker_route,
  output wire analog_active,
  output wire left_adc_mode,
  output wire right_adc_mode,
  output wire [1:0] analog_mode,
  output wire full_duplex_out_link,
  output wire full_duplex_in_link,
  output reg serial_port_enable,
  output wire data_signed,
  output wire frame_sync_low,
  output wire test_pins_out,
  output wire dac_from_first,
  output wire filter_div_active,
  output wire [3:0] filter_divisor,
  output reg [SHIFT_W-1:0] serial_shift,
  output reg lr_toggle
);
  reg [7:0] index_reg;
  reg [7:0] stereo_reg, legacy_mv_reg, synth_reg, cd_reg, aux_reg, spk_reg, line_reg;
  reg [7:0] portcfg_reg, sin_reg, sout_reg, sana_reg, smisc_reg, sdiv_reg;
  reg [7:0] left_mv_reg, right_mv_reg, mv_ctrl_reg;
  reg [7:0] emu_vol_next;
  reg bclk_d1_reg, bclk_d2_reg, bclk_q_reg;
  wire data_wr;
  wire mixer_rst;
  wire bclk_rise;
  wire in_ovr;

  // index and data port strobes
  assign data_wr = io_wr && (io_addr == `MSCR_DATA_PORT);
  assign mixer_rst = data_wr && (index_reg == `MSCR_OFF_RESET);

  // legacy nibble to 6-bit master volume, mute on zero
  always @* begin
    case (io_wdata[7:4])
      4'h0: emu_vol_next = 8'h58;
      4'h1: emu_vol_next = 8'h18;
      4'h2: emu_vol_next = 8'h1e;
      4'h3: emu_vol_next = 8'h22;
      4'h4: emu_vol_next = 8'h26;
      4'h5: emu_vol_next = 8'h2a;
      4'h6: emu_vol_next = 8'h2e;
      4'h7: emu_vol_next = 8'h32;
      4'h8: emu_vol_next = 8'h36;
      4'h9: emu_vol_next = 8'h37;
      4'ha: emu_vol_next = 8'h38;
      4'hb: emu_vol_next = 8'h3a;
      4'hc: emu_vol_next = 8'h3b;
      4'hd: emu_vol_next = 8'h3d;
      4'he: emu_vol_next = 8'h3e;
      default: emu_vol_next = 8'h3f;
    endcase
  end

  // register writes; mixer reset restores mixer values but leaves port config
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      index_reg <= 8'h00;
      stereo_reg <= `MSCR_RST_STEREO;
      legacy_mv_reg <= `MSCR_RST_LEGACY_MV;
      synth_reg <= `MSCR_RST_SYNTH;
      cd_reg <= `MSCR_RST_CD;
      aux_reg <= `MSCR_RST_AUX;
      spk_reg <= `MSCR_RST_SPK;
      line_reg <= `MSCR_RST_LINE;
      portcfg_reg <= `MSCR_RST_PORTCFG;
      sin_reg <= `MSCR_RST_SERIAL;
      sout_reg <= `MSCR_RST_SERIAL;
      sana_reg <= `MSCR_RST_SERIAL;
      smisc_reg <= `MSCR_RST_SERIAL;
      sdiv_reg <= `MSCR_RST_SERIAL;
      left_mv_reg <= `MSCR_RST_MASTER;
      right_mv_reg <= `MSCR_RST_MASTER;
      mv_ctrl_reg <= `MSCR_RST_MV_CTRL;
      device_disable <= 1'b0;
    end else begin
      if (io_wr && io_addr == `MSCR_IDX_PORT) begin
        index_reg <= io_wdata;
      end
      if (mixer_rst) begin
        stereo_reg <= `MSCR_RST_STEREO;
        legacy_mv_reg <= `MSCR_RST_LEGACY_MV;
        synth_reg <= `MSCR_RST_SYNTH;
        cd_reg <= `MSCR_RST_CD;
        aux_reg <= `MSCR_RST_AUX;
        spk_reg <= `MSCR_RST_SPK;
        line_reg <= `MSCR_RST_LINE;
        if (!mv_ctrl_reg[`MSCR_BIT_EMU_DIS]) begin
          left_mv_reg <= `MSCR_RST_MASTER;
          right_mv_reg <= `MSCR_RST_MASTER;
        end
      end else if (data_wr) begin
        case (index_reg)
          `MSCR_OFF_STEREO: stereo_reg <= io_wdata;
          `MSCR_OFF_LEGACY_MV: begin
            // disabled emulation makes the legacy register read-only
            if (!mv_ctrl_reg[`MSCR_BIT_EMU_DIS]) begin
              legacy_mv_reg <= io_wdata;
              left_mv_reg <= emu_vol_next;
              right_mv_reg <= emu_vol_next;
            end
          end
          `MSCR_OFF_SYNTH: synth_reg <= io_wdata;
          `MSCR_OFF_CD: cd_reg <= io_wdata;
          `MSCR_OFF_AUX: aux_reg <= io_wdata;
          `MSCR_OFF_SPK: spk_reg <= io_wdata;
          `MSCR_OFF_LINE: line_reg <= io_wdata;
          `MSCR_OFF_PORTCFG: begin
            portcfg_reg <= {io_wdata[7:3], 1'b0, io_wdata[1:0]};
            if (io_wdata[`MSCR_BIT_RESTART]) begin
              device_disable <= 1'b1;
            end
          end
          `MSCR_OFF_SIN: sin_reg <= io_wdata;
          `MSCR_OFF_SOUT: sout_reg <= io_wdata;
          `MSCR_OFF_SANA: sana_reg <= io_wdata;
          `MSCR_OFF_SMISC: smisc_reg <= io_wdata;
          `MSCR_OFF_SDIV: sdiv_reg <= io_wdata;
          `MSCR_OFF_LEFT_MV: left_mv_reg <= {1'b0, io_wdata[6:0]};
          `MSCR_OFF_RIGHT_MV: right_mv_reg <= {1'b0, io_wdata[6:0]};
          `MSCR_OFF_MV_CTRL: mv_ctrl_reg <= io_wdata;
          default: ;
        endcase
      end
    end
  end

  // read mux; unmapped indexes read zero, restart bit always reads zero
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (io_rd && io_addr == `MSCR_IDX_PORT) begin
      io_rdata <= index_reg;
    end else if (io_rd && io_addr == `MSCR_DATA_PORT) begin
      case (index_reg)
        `MSCR_OFF_STEREO: io_rdata <= stereo_reg;
        `MSCR_OFF_LEGACY_MV: io_rdata <= legacy_mv_reg;
        `MSCR_OFF_SYNTH: io_rdata <= synth_reg;
        `MSCR_OFF_CD: io_rdata <= cd_reg;
        `MSCR_OFF_AUX: io_rdata <= aux_reg;
        `MSCR_OFF_SPK: io_rdata <= spk_reg;
        `MSCR_OFF_LINE: io_rdata <= line_reg;
        `MSCR_OFF_PORTCFG: io_rdata <= portcfg_reg;
        `MSCR_OFF_SIN: io_rdata <= sin_reg;
        `MSCR_OFF_SOUT: io_rdata <= sout_reg;
        `MSCR_OFF_SANA: io_rdata <= sana_reg;
        `MSCR_OFF_SMISC: io_rdata <= smisc_reg;
        `MSCR_OFF_SDIV: io_rdata <= sdiv_reg;
        `MSCR_OFF_LEFT_MV: io_rdata <= left_mv_reg;
        `MSCR_OFF_RIGHT_MV: io_rdata <= right_mv_reg;
        `MSCR_OFF_MV_CTRL: io_rdata <= mv_ctrl_reg;
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // mixer volume fields
  assign stereo_dac_enable = stereo_reg[`MSCR_BIT_STEREO];
  assign synth_vol_left = synth_reg[7:4];
  assign synth_vol_right = synth_reg[3:0];
  assign cd_vol_left = cd_reg[7:4];
  assign cd_vol_right = cd_reg[3:0];
  assign aux_vol_left = aux_reg[7:4];
  assign aux_vol_right = aux_reg[3:0];
  assign line_vol_left = line_reg[7:4];
  assign line_vol_right = line_reg[3:0];
  assign speaker_atten = spk_reg[2:0];
  assign left_master_vol = left_mv_reg;
  assign right_master_vol = right_mv_reg;

  // port decode; codes 011..111 map onto lines e,a,b,c,d in that order
  assign midi_enable = (portcfg_reg[7:5] != 3'b000);
  assign midi_irq_share = (portcfg_reg[7:5] == 3'b010);
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_irq
      assign midi_irq_lines[gi] = (portcfg_reg[7:5] == gi + 3);
    end
  endgenerate
  assign midi_base = `MSCR_MIDI_BASE + {4'h0, portcfg_reg[4:3], 4'h0};
  assign midi_hit = midi_enable && !device_disable && (decode_addr[9:1] == midi_base[9:1]);
  assign joystick_hit = portcfg_reg[`MSCR_BIT_JOY] && !device_disable &&
                        (decode_addr == `MSCR_JOY_ADDR);
  // alias hit only adds decode; the normal synth window is decoded elsewhere
  assign synth_alias_hit = portcfg_reg[`MSCR_BIT_SYNTH_ALIAS] && !device_disable &&
                           (decode_addr >= `MSCR_ALIAS_LO) &&
                           (decode_addr <= `MSCR_ALIAS_HI);

  // serial input override
  assign in_ovr = serial_mode && sin_reg[`MSCR_BIT_OVERRIDE];
  assign eff_input_source = in_ovr ? sin_reg[5:4] : app_input_source;
  assign eff_input_volume = in_ovr ? sin_reg[3:0] : app_input_volume;
  assign mic_preamp_bypass = in_ovr && sin_reg[`MSCR_BIT_PREAMP];

  // serial output: volume needs override, routing does not
  assign eff_output_volume = (serial_mode && sout_reg[`MSCR_BIT_OVERRIDE]) ?
                             sout_reg[3:0] : left_mv_reg[5:2];
  assign speaker_route = serial_mode ? sout_reg[6:4] : 3'b100;

  // analog routing only when its override bit is set in serial mode
  assign analog_active = serial_mode && sana_reg[7];
  assign left_adc_mode = analog_active && sana_reg[5];
  assign right_adc_mode = analog_active && sana_reg[4];
  assign analog_mode = analog_active ? sana_reg[3:2] : 2'b00;
  assign full_duplex_out_link = analog_active && sana_reg[1] &&
                                !smisc_reg[`MSCR_BIT_SRESET];
  assign full_duplex_in_link = analog_active && sana_reg[0];

  // misc serial control fields
  assign data_signed = smisc_reg[`MSCR_BIT_FORMAT];
  assign frame_sync_low = smisc_reg[`MSCR_BIT_SYNC_LOW];
  assign test_pins_out = smisc_reg[`MSCR_BIT_TEST];
  assign dac_from_first = serial_mode && smisc_reg[`MSCR_BIT_TELEGAME];
  assign filter_div_active = serial_mode && sdiv_reg[7];
  assign filter_divisor = sdiv_reg[3:0];

  // bit clock sampled through two flops; enable only moves on a rising edge
  assign bclk_rise = bclk_d2_reg && !bclk_q_reg;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bclk_d1_reg <= 1'b0;
      bclk_d2_reg <= 1'b0;
      bclk_q_reg <= 1'b0;
      serial_port_enable <= 1'b0;
      serial_shift <= {SHIFT_W{1'b0}};
      lr_toggle <= 1'b0;
    end else begin
      bclk_d1_reg <= serial_bit_clock_in;
      bclk_d2_reg <= bclk_d1_reg;
      bclk_q_reg <= bclk_d2_reg;
      if (bclk_rise) begin
        serial_port_enable <= smisc_reg[`MSCR_BIT_PORT_EN];
      end
      if (smisc_reg[`MSCR_BIT_SRESET]) begin
        serial_shift <= {SHIFT_W{1'b0}};
        lr_toggle <= 1'b0;
      end else if (bclk_rise && serial_port_enable) begin
        serial_shift <= {serial_shift[SHIFT_W-2:0], serial_rx_bit};
        lr_toggle <= ~lr_toggle;
      end
    end
  end
endmodule // mscr_regs
`default_nettype wire

// File: verif/mscr_monitor.sv
// checker for the mixer configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module mscr_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic [9:0] decode_addr,
  input wire logic serial_mode,
  input wire logic serial_bit_clock_in,
  input wire logic [1:0] app_input_source,
  input wire logic [3:0] app_input_volume,
  input wire logic stereo_dac_enable,
  input wire logic [2:0] speaker_atten,
  input wire logic [7:0] left_master_vol,
  input wire logic [7:0] right_master_vol,
  input wire logic [9:0] midi_base,
  input wire logic device_disable,
  input wire logic joystick_hit,
  input wire logic [1:0] eff_input_source,
  input wire logic [3:0] eff_input_volume,
  input wire logic full_duplex_out_link,
  input wire logic serial_port_enable
);
  logic [7:0] idx_reg;
  logic [7:0] wd_reg;
  logic mv_dis_reg;
  // shadow of the index and emulation-disable bit, rebuilt from host traffic
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      idx_reg <= 8'h00;
      mv_dis_reg <= 1'b0;
    end else if (io_wr && io_addr == 3'h4) begin
      idx_reg <= io_wdata;
    end else if (io_wr && io_addr == 3'h5 && idx_reg == 8'h64) begin
      mv_dis_reg <= io_wdata[0];
    end
  end
  // last data byte, so a consequent can look back without $past on a slice
  always_ff @(posedge sys_clk) begin
    wd_reg <= io_wdata;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_wr(logic [7:0] off);
    io_wr && io_addr == 3'h5 && idx_reg == off;
  endsequence
  property p_stereo; s_wr(8'h1e) |=> stereo_dac_enable == wd_reg[1]; endproperty
  a_stereo: assert property (p_stereo) else $error("stereo flag wrong");
  property p_spk; s_wr(8'h3c) |=> speaker_atten == wd_reg[2:0]; endproperty
  a_spk: assert property (p_spk) else $error("speaker code wrong");
  property p_midi; s_wr(8'h40) |=> midi_base == (10'h300 | {4'h0, wd_reg[4:3], 4'h0}); endproperty
  a_midi: assert property (p_midi) else $error("midi base wrong");
  property p_off; s_wr(8'h40) ##0 io_wdata[2] |=> device_disable [*8]; endproperty
  a_off: assert property (p_off) else $error("restart did not disable");
  property p_joy; joystick_hit |-> decode_addr == 10'h201; endproperty
  a_joy: assert property (p_joy) else $error("joystick hit off address");
  property p_noser;
    !serial_mode |-> eff_input_source == app_input_source && eff_input_volume == app_input_volume;
  endproperty
  a_noser: assert property (p_noser) else $error("input override outside serial");
  property p_fdx; s_wr(8'h48) ##0 io_wdata[5] |=> !full_duplex_out_link; endproperty
  a_fdx: assert property (p_fdx) else $error("link not inhibited");
  property p_hold; !io_rd |=> $stable(io_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_leg;
    s_wr(8'h32) ##0 !mv_dis_reg |=> left_master_vol == right_master_vol && !left_master_vol[7];
  endproperty
  a_leg: assert property (p_leg) else $error("legacy write split");
  property p_se;
    $rose(serial_port_enable) |-> $past(serial_bit_clock_in) || $past(serial_bit_clock_in, 2) ||
      $past(serial_bit_clock_in, 3) || $past(serial_bit_clock_in, 4) || $past(serial_bit_clock_in, 5);
  endproperty
  a_se: assert property (p_se) else $error("enable without bit clock");
endmodule // mscr_monitor
bind mscr_regs mscr_monitor u_mon (.sys_clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata,
  .io_rdata, .decode_addr, .serial_mode, .serial_bit_clock_in, .app_input_source,
  .app_input_volume, .stereo_dac_enable, .speaker_atten, .left_master_vol, .right_master_vol,
  .midi_base, .device_disable, .joystick_hit, .eff_input_source, .eff_input_volume,
  .full_duplex_out_link, .serial_port_enable);
`default_nettype wire

// File: verif/mscr_host.sv
// host model reaching the bank through the index and data ports
`timescale 1ns/1ps
`default_nettype none
module mscr_host (
  input wire logic sys_clk,
  output logic [2:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 3'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one strobe cycle; released data goes to its inverse so stale bytes never look valid
  task automatic port_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge sys_clk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    port_wr(3'h4, off);
    port_wr(3'h5, d);
  endtask
  // data is taken one edge after the strobe, where it already stands
  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    port_wr(3'h4, off);
    @(posedge sys_clk);
    io_addr <= 3'h5;
    io_rd <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    @(posedge sys_clk);
    d = io_rdata;
  endtask
endmodule // mscr_host
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the mixer configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] off, rst, wd, rd;} mscr_row_t;
  logic sys_clk = 1'b0;
  logic reset, io_wr, io_rd, serial_mode, serial_bit_clock_in, stereo_dac_enable, device_disable;
  logic joystick_hit, mic_preamp_bypass, left_adc_mode, right_adc_mode, full_duplex_out_link;
  logic serial_port_enable, data_signed, frame_sync_low, dac_from_first, lr_toggle;
  logic serial_rx_bit, synth_alias_hit, midi_hit, midi_enable, midi_irq_share, test_pins_out;
  logic filter_div_active, analog_active, full_duplex_in_link;
  logic [3:0] cd_vol_left, cd_vol_right, aux_vol_left, aux_vol_right;
  logic [3:0] line_vol_left, line_vol_right;
  logic [1:0] app_input_source, eff_input_source, analog_mode;
  logic [2:0] io_addr, speaker_atten, speaker_route;
  logic [3:0] synth_vol_left, synth_vol_right, app_input_volume, eff_input_volume;
  logic [3:0] eff_output_volume, filter_divisor;
  logic [4:0] midi_irq_lines;
  logic [7:0] io_wdata, io_rdata, left_master_vol, right_master_vol, rdv;
  logic [9:0] decode_addr, midi_base;
  logic [15:0] serial_shift;
  int miscompares, tests_run;
  // offset, reset value, byte written, byte read back
  mscr_row_t rows [14] = '{32'h1e00_2222, 32'h3288_8888, 32'h3688_5a5a, 32'h3800_a5a5,
    32'h3a00_3c3c, 32'h3c04_0808, 32'h3e00_c3c3, 32'h4000_ebeb, 32'h4200_a7a7,
    32'h4400_c5c5, 32'h4600_acac, 32'h4800_4a4a, 32'h4c00_8e8e, 32'h5000_5500};
  always #20 sys_clk = ~sys_clk;
  mscr_host host (.sys_clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
  mscr_regs DUT (.sys_clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .decode_addr, .serial_mode, .serial_bit_clock_in, .serial_rx_bit,
    .stereo_dac_enable, .synth_vol_left, .synth_vol_right, .cd_vol_left, .cd_vol_right,
    .aux_vol_left, .aux_vol_right, .line_vol_left, .line_vol_right, .speaker_atten,
    .left_master_vol, .right_master_vol, .midi_enable, .midi_irq_share, .midi_irq_lines,
    .midi_base, .midi_hit, .device_disable, .joystick_hit, .synth_alias_hit,
    .app_input_source, .app_input_volume, .eff_input_source, .eff_input_volume,
    .mic_preamp_bypass, .eff_output_volume, .speaker_route, .analog_active, .left_adc_mode,
    .right_adc_mode, .analog_mode, .full_duplex_out_link, .full_duplex_in_link,
    .serial_port_enable, .data_signed, .frame_sync_low, .test_pins_out, .dac_from_first,
    .filter_div_active, .filter_divisor, .serial_shift, .lr_toggle);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a whole run is far below 10000 cycles; beyond that something hangs
  initial begin
    #400000;
    miscompares++;
    results();
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    reset = 1'b1;
    serial_mode = 1'b0;
    serial_bit_clock_in = 1'b0;
    serial_rx_bit = 1'b0;
    decode_addr = 10'h000;
    app_input_source = 2'h1;
    app_input_volume = 4'h9;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      host.rd(rows[i].off, rdv);
      chk(rdv, rows[i].rst);
    end
    $display("test reset values done");
    // bit 5 of 1eh and reserved bits are stored but steer nothing
    foreach (rows[i]) begin
      host.wr(rows[i].off, rows[i].wd);
      host.rd(rows[i].off, rdv);
      chk(rdv, rows[i].rd);
    end
    $display("test register rows done");
    decode_addr <= 10'h201;
    @(posedge sys_clk) #1;
    chk({joystick_hit, midi_irq_share, midi_irq_lines, midi_base},
      {1'b1, 1'b0, 5'h10, 10'h310});
    chk({stereo_dac_enable, synth_vol_left, synth_vol_right, speaker_atten}, 12'had0);
    chk({cd_vol_left, cd_vol_right, aux_vol_left, aux_vol_right, line_vol_left, line_vol_right},
      24'ha5_3cc3);
    decode_addr <= 10'h388;
    @(posedge sys_clk) #1;
    chk({joystick_hit, synth_alias_hit, midi_hit}, 3'b010);
    decode_addr <= 10'h310;
    @(posedge sys_clk) #1;
    chk({synth_alias_hit, midi_hit, midi_enable}, 3'b011);
    $display("test decode done");
    serial_mode <= 1'b1;
    @(posedge sys_clk) #1;
    chk({eff_input_source, eff_input_volume, mic_preamp_bypass}, 7'h4e);
    chk({eff_output_volume, speaker_route}, {4'h5, 3'h4});
    chk({analog_active, left_adc_mode, right_adc_mode, analog_mode, full_duplex_in_link},
      6'h36);
    chk({data_signed, frame_sync_low, test_pins_out, dac_from_first, filter_div_active,
      filter_divisor}, 9'h1be);
    serial_mode <= 1'b0;
    @(posedge sys_clk) #1;
    chk({eff_input_source, eff_input_volume}, 6'h19);
    $display("test serial overrides done");
    // bit clock stopped: the enable must wait for a real edge; link open before serial reset
    serial_mode <= 1'b1;
    serial_rx_bit <= 1'b1;
    host.wr(8'h46, 8'h82);
    host.wr(8'h48, 8'h80);
    repeat (10) @(posedge sys_clk);
    #1;
    chk({serial_port_enable, full_duplex_out_link}, 2'b01);
    repeat (4) begin
      repeat (3) @(posedge sys_clk);
      serial_bit_clock_in <= ~serial_bit_clock_in;
    end
    repeat (6) @(posedge sys_clk);
    #1;
    // first rise only enables, second rise shifts one bit in
    chk({serial_port_enable, full_duplex_out_link, lr_toggle, serial_shift}, 19'h7_0001);
    host.wr(8'h48, 8'ha0);
    @(posedge sys_clk) #1;
    chk({serial_port_enable, full_duplex_out_link, lr_toggle, serial_shift}, 19'h4_0000);
    serial_mode <= 1'b0;
    $display("test serial port done");
    host.wr(8'h32, 8'h00);
    @(posedge sys_clk) #1;
    chk({left_master_vol, right_master_vol}, 16'h5858);
    host.wr(8'h64, 8'h01);
    host.wr(8'h32, 8'h88);
    @(posedge sys_clk) #1;
    chk(left_master_vol, 8'h58);
    host.wr(8'h64, 8'h00);
    $display("test legacy master done");
    host.wr(8'h00, 8'hff);
    host.rd(8'h3c, rdv);
    chk(rdv, 8'h04);
    host.rd(8'h36, rdv);
    chk(rdv, 8'h88);
    host.rd(8'h40, rdv);
    chk(rdv, 8'heb);
    host.rd(8'h42, rdv);
    chk({rdv, left_master_vol}, 16'ha736);
    $display("test mixer reset done");
    host.wr(8'h40, 8'hff);
    @(posedge sys_clk) #1;
    chk(device_disable, 1'b1);
    host.rd(8'h40, rdv);
    chk({rdv, midi_base}, {8'hfb, 10'h330});
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    host.rd(8'h40, rdv);
    chk({rdv, device_disable, midi_base}, {8'h00, 1'b0, 10'h300});
    $display("test restart done");
    results();
  end
endmodule // testbench
`default_nettype wire
